/* File: dpcfg_defines.svh */
`ifndef DPCFG_DEFINES_SVH
`define DPCFG_DEFINES_SVH

//----------------------------------------------------------
// Register offsets (byte addresses)
//----------------------------------------------------------
`define DPCFG_OFF_P4_DATA     12'h000
`define DPCFG_OFF_P4_OUT      12'h004
`define DPCFG_OFF_P4_FSA      12'h00c
`define DPCFG_OFF_P4_FSB      12'h010
`define DPCFG_OFF_P4_PUP      12'h02c
`define DPCFG_OFF_P4_IE       12'h038
`define DPCFG_OFF_P8_FSB      12'h110
`define DPCFG_OFF_P8_PUP      12'h12c
`define DPCFG_OFF_P8_IE       12'h138

//----------------------------------------------------------
// Field masks and reset values
//----------------------------------------------------------
`define DPCFG_P4_MASK         4'hf
`define DPCFG_P4_FSA_MASK     4'h3
`define DPCFG_P8_FSB_MASK     8'hc0
`define DPCFG_P8_MASK         8'hff
`define DPCFG_RST4            4'h0
`define DPCFG_RST8            8'h00
`endif

/* File: dpcfg_pkg.sv */
package dpcfg_pkg;
   // Four-pin and eight-pin vectors
   typedef logic [3:0] dpcfg_nib_t;
   typedef logic [7:0] dpcfg_byte_t;
endpackage : dpcfg_pkg

/* File: dpcfg_top.sv */
`timescale 1ns/1ps
`include "dpcfg_defines.svh"
module dpcfg_top
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               stop_mode,
   input  wire dpcfg_pkg::dpcfg_nib_t  p4_pin_in,
   output dpcfg_pkg::dpcfg_nib_t   p4_pin_out,
   output dpcfg_pkg::dpcfg_nib_t   p4_pin_oe,
   output dpcfg_pkg::dpcfg_nib_t   p4_pullup_en,
   output dpcfg_pkg::dpcfg_nib_t   p4_analog_in,
   output logic                    ext_irq_in3,
   output logic                    ext_irq_in2,
   output logic                    timer6_capture_in1,
   output logic                    timer6_capture_in0,
   output logic                    timer1_capture_in1,
   output logic                    timer1_capture_in0,
   input  wire dpcfg_pkg::dpcfg_byte_t p8_pin_in,
   output dpcfg_pkg::dpcfg_byte_t  p8_pullup_en,
   output dpcfg_pkg::dpcfg_byte_t  p8_input_en,
   output logic                    timer0_capture_in1,
   output logic                    timer0_capture_in0
);

   //-------------------------------------------------------
   // Register storage
   //-------------------------------------------------------
   dpcfg_pkg::dpcfg_nib_t  data_reg;     // Output data latch
   dpcfg_pkg::dpcfg_nib_t  out_reg;      // Output enables
   dpcfg_pkg::dpcfg_nib_t  fsa_reg;      // Select a, bits 1:0
   dpcfg_pkg::dpcfg_nib_t  fsb_reg;      // Select b
   dpcfg_pkg::dpcfg_nib_t  pup_reg;      // Pull-up enables
   dpcfg_pkg::dpcfg_nib_t  ie_reg;       // Input enables
   dpcfg_pkg::dpcfg_byte_t p8fsb_reg;    // Port8 select b
   dpcfg_pkg::dpcfg_byte_t p8pup_reg;    // Port8 pull-ups
   dpcfg_pkg::dpcfg_byte_t p8ie_reg;     // Port8 input enables
   logic [31:0]            rdata_next;   // Read mux value

   //-------------------------------------------------------
   // Bus decode
   //-------------------------------------------------------
   wire wr_en   = psel & penable & pwrite;
   wire rd_en   = psel & penable & ~pwrite;
   wire hit_dat = (paddr == `DPCFG_OFF_P4_DATA);
   wire hit_out = (paddr == `DPCFG_OFF_P4_OUT);
   wire hit_fsa = (paddr == `DPCFG_OFF_P4_FSA);
   wire hit_fsb = (paddr == `DPCFG_OFF_P4_FSB);
   wire hit_pup = (paddr == `DPCFG_OFF_P4_PUP);
   wire hit_ie  = (paddr == `DPCFG_OFF_P4_IE);
   wire hit_8fs = (paddr == `DPCFG_OFF_P8_FSB);
   wire hit_8pu = (paddr == `DPCFG_OFF_P8_PUP);
   wire hit_8ie = (paddr == `DPCFG_OFF_P8_IE);
   wire hit_any = hit_dat | hit_out | hit_fsa | hit_fsb | hit_pup
                | hit_ie | hit_8fs | hit_8pu | hit_8ie;

   // Zero-wait slave; unmapped access answers with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   //-------------------------------------------------------
   // Pin side
   //-------------------------------------------------------
   // Gated input: disabled pins read zero and stay quiet
   wire [3:0] p4_in_g = p4_pin_in & ie_reg;
   wire [7:0] p8_in_g = p8_pin_in & p8ie_reg;
   // Plain I/O when both select bits are zero
   wire [3:0] gpio_m  = ~(fsa_reg | fsb_reg);
   // Interrupt path ignores selects, blocked in stop mode
   wire [3:0] irq_g   = p4_in_g & {4{~stop_mode}};

   //-------------------------------------------------------
   // Per-pin alternate routing
   //-------------------------------------------------------
   wire [3:0] cap_g;                   // Capture path per pin
   wire [3:0] alt_m;                   // Pin handed to a peripheral
   genvar     gi;                      // Pin index
   generate
      for (gi = 0; gi < 4; gi++)
      begin : pin_g
         // Capture only through an enabled input
         assign cap_g[gi] = p4_in_g[gi] & fsb_reg[gi];
         // Alternate when either select bit is set
         assign alt_m[gi] = fsa_reg[gi] | fsb_reg[gi];
         // Driver must drop once the pin is handed over
         pin_oe_a: assert property (@(posedge pclk)
            disable iff (!presetn) alt_m[gi] |-> !p4_pin_oe[gi])
            else $error("Driver on for handed-over pin");
      end
   endgenerate

   assign p4_pin_out   = data_reg;
   assign p4_pin_oe    = out_reg & gpio_m;
   assign p4_pullup_en = pup_reg;
   // Analog path available once input and pull-up are off
   assign p4_analog_in = ~ie_reg & ~pup_reg;
   assign ext_irq_in3  = irq_g[1];
   assign ext_irq_in2  = irq_g[0];
   assign timer6_capture_in1 = cap_g[3];
   assign timer6_capture_in0 = cap_g[2];
   assign timer1_capture_in1 = cap_g[1];
   assign timer1_capture_in0 = cap_g[0];
   assign timer0_capture_in1 = p8_in_g[7] & p8fsb_reg[7];
   assign timer0_capture_in0 = p8_in_g[6] & p8fsb_reg[6];
   assign p8_pullup_en = p8pup_reg;
   assign p8_input_en  = p8ie_reg;

   //-------------------------------------------------------
   // Read mux, upper bits zero
   //-------------------------------------------------------
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (hit_dat)
         // Pin level for inputs, latch for outputs
         rdata_next[3:0] = (p4_in_g & ~out_reg) | (data_reg & out_reg);
      else if (hit_out)
         rdata_next[3:0] = out_reg;
      else if (hit_fsa)
         rdata_next[3:0] = fsa_reg;
      else if (hit_fsb)
         rdata_next[3:0] = fsb_reg;
      else if (hit_pup)
         rdata_next[3:0] = pup_reg;
      else if (hit_ie)
         rdata_next[3:0] = ie_reg;
      else if (hit_8fs)
         rdata_next[7:0] = p8fsb_reg;
      else if (hit_8pu)
         rdata_next[7:0] = p8pup_reg;
      else if (hit_8ie)
         rdata_next[7:0] = p8ie_reg;
   end

   // Read data flop, loaded in setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel & ~penable & ~pwrite)
         prdata <= rdata_next;
   end

   //-------------------------------------------------------
   // Register writes
   //-------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // All pins plain, every enable off
         data_reg  <= `DPCFG_RST4;
         out_reg   <= `DPCFG_RST4;
         fsa_reg   <= `DPCFG_RST4;
         fsb_reg   <= `DPCFG_RST4;
         pup_reg   <= `DPCFG_RST4;
         ie_reg    <= `DPCFG_RST4;
         p8fsb_reg <= `DPCFG_RST8;
         p8pup_reg <= `DPCFG_RST8;
         p8ie_reg  <= `DPCFG_RST8;
      end
      else if (wr_en)
      begin
         if (hit_dat) data_reg  <= pwdata[3:0] & `DPCFG_P4_MASK;
         if (hit_out) out_reg   <= pwdata[3:0] & `DPCFG_P4_MASK;
         if (hit_fsa) fsa_reg   <= pwdata[3:0] & `DPCFG_P4_FSA_MASK;
         if (hit_fsb) fsb_reg   <= pwdata[3:0] & `DPCFG_P4_MASK;
         if (hit_pup) pup_reg   <= pwdata[3:0] & `DPCFG_P4_MASK;
         if (hit_ie)  ie_reg    <= pwdata[3:0] & `DPCFG_P4_MASK;
         if (hit_8fs) p8fsb_reg <= pwdata[7:0] & `DPCFG_P8_FSB_MASK;
         if (hit_8pu) p8pup_reg <= pwdata[7:0] & `DPCFG_P8_MASK;
         if (hit_8ie) p8ie_reg  <= pwdata[7:0] & `DPCFG_P8_MASK;
      end
   end

   //-------------------------------------------------------
   // Checks
   //-------------------------------------------------------
   gate_in_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ie_reg[2] |-> !timer6_capture_in0)
      else $error("Capture seen with input off");
   irq_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      stop_mode |-> !ext_irq_in3 && !ext_irq_in2)
      else $error("Interrupt passed in stop mode");
   irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!stop_mode && ie_reg[1]) |-> ext_irq_in3 == p4_pin_in[1])
      else $error("Interrupt does not follow pin");
   oe_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
      (fsb_reg[0] || fsa_reg[0]) |-> !p4_pin_oe[0])
      else $error("Driver on in alternate mode");
   oe_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_out) |=> out_reg == $past(pwdata[3:0]))
      else $error("Output control not stored");
   p8_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
      p8fsb_reg[5:0] == 6'h00)
      else $error("Port8 select low bits set");
   fsa_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
      fsa_reg[3:2] == 2'h0)
      else $error("Select a upper bits set");
   p8pup_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_8pu) |=> p8_pullup_en == $past(pwdata[7:0]))
      else $error("Port8 pull-up not stored");
   p8ie_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_8ie) |=> p8_input_en == $past(pwdata[7:0]))
      else $error("Port8 input enable not stored");
   rd_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && hit_dat && !pwrite) |=> prdata[31:4] == 28'h0)
      else $error("Data upper bits not zero");
   analog_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!ie_reg[3] && !pup_reg[3]) |-> p4_analog_in[3])
      else $error("Analog path not offered");
   reset_a: assert property (@(posedge pclk)
      $rose(presetn) |-> p4_pin_oe == 4'h0 && p4_pullup_en == 4'h0)
      else $error("Pins not idle after reset");

   //-------------------------------------------------------
   // Register write checks
   //-------------------------------------------------------
   // Select b takes all four bits
   fsb_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_fsb) |=> fsb_reg == $past(pwdata[3:0]))
      else $error("Select b not stored");
   // Select a keeps only its two low bits
   fsa_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_fsa) |=> fsa_reg == {2'b00, $past(pwdata[1:0])})
      else $error("Select a not stored");
   // Pull-up register reached at its offset
   pup_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_pup) |=> p4_pullup_en == $past(pwdata[3:0]))
      else $error("Pull-up not stored");
   // Input enable reached at its offset
   ie_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_ie) |=> ie_reg == $past(pwdata[3:0]))
      else $error("Input enable not stored");
   // Data latch drives the pin value
   dat_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_dat) |=> p4_pin_out == $past(pwdata[3:0]))
      else $error("Data latch not stored");
   // Port8 select keeps bits 7:6 only
   p8fsb_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit_8fs) |=> p8fsb_reg == {$past(pwdata[7:6]), 6'h00})
      else $error("Port8 select not stored");
   // Unmapped write leaves output control and input enable alone
   wr_bad_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && !hit_any) |=> $stable(out_reg) && $stable(ie_reg))
      else $error("Unmapped write changed state");

   //-------------------------------------------------------
   // Gating and routing checks
   //-------------------------------------------------------
   // Interrupt 2 blocked with input off
   irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ie_reg[0] |-> !ext_irq_in2)
      else $error("Interrupt seen with input off");
   // Timer1 capture blocked with input off
   t1_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ie_reg[1] |-> !timer1_capture_in1)
      else $error("Timer1 capture with input off");
   // Timer0 capture needs its select bit
   t0_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !p8fsb_reg[7] |-> !timer0_capture_in1)
      else $error("Timer0 capture without select");
   // Timer0 capture follows its pin
   t0_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      (p8fsb_reg[6] && p8ie_reg[6]) |-> timer0_capture_in0 == p8_pin_in[6])
      else $error("Timer0 capture does not follow pin");
   // Timer6 capture follows its pin
   t6_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      (fsb_reg[3] && ie_reg[3]) |-> timer6_capture_in1 == p4_pin_in[3])
      else $error("Timer6 capture does not follow pin");
   // Interrupt 2 follows its pin outside stop
   irq2_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!stop_mode && ie_reg[0]) |-> ext_irq_in2 == p4_pin_in[0])
      else $error("Interrupt 2 does not follow pin");
   // Driver on for a plain output pin
   oe_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      (out_reg[1] && !fsa_reg[1] && !fsb_reg[1]) |-> p4_pin_oe[1])
      else $error("Driver off for plain output");
   // Analog path closed while input on
   analog_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      ie_reg[0] |-> !p4_analog_in[0])
      else $error("Analog path with input on");

   //-------------------------------------------------------
   // Bus answer checks
   //-------------------------------------------------------
   // Unmapped access answers with an error
   err_map_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !hit_any) |-> pslverr)
      else $error("Unmapped access not refused");
   // Unmapped read returns zero
   rd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && !hit_any) |=> prdata == 32'h0)
      else $error("Unmapped read not zero");
   // Select a reads back its value
   rd_fsa_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_fsa)
      |=> prdata == {28'h0, $past(fsa_reg)})
      else $error("Select a read wrong");
   // Output control reads back its value
   rd_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_out)
      |=> prdata == {28'h0, $past(out_reg)})
      else $error("Output control read wrong");

endmodule : dpcfg_top

/* File: dpcfg_pin_model.sv */
`timescale 1ns/1ps
// Pad model: pins driven by the block, the outside, or pull-ups
module dpcfg_pin_model
(
   input  wire logic                   pclk,
   input  wire dpcfg_pkg::dpcfg_nib_t  p4_pin_out,
   input  wire dpcfg_pkg::dpcfg_nib_t  p4_pin_oe,
   input  wire dpcfg_pkg::dpcfg_nib_t  p4_pullup_en,
   input  wire dpcfg_pkg::dpcfg_nib_t  ext4,
   input  wire dpcfg_pkg::dpcfg_nib_t  ext4_drv,
   output dpcfg_pkg::dpcfg_nib_t       p4_pin_in
);
   dpcfg_pkg::dpcfg_nib_t float_reg;   // Noise on a floating pad
   // Pattern that changes every cycle
   always_ff @(posedge pclk)
      float_reg <= (float_reg === 4'h5) ? 4'ha : 4'h5;
   // Block driver wins, then outside driver, then pull-up
   assign p4_pin_in = (p4_pin_oe & p4_pin_out)
      | (~p4_pin_oe & ext4_drv & ext4)
      | (~p4_pin_oe & ~ext4_drv & p4_pullup_en)
      | (~p4_pin_oe & ~ext4_drv & ~p4_pullup_en & float_reg);
endmodule : dpcfg_pin_model

/* File: dual_port_pin_config_test.sv */
`timescale 1ns/1ps
`include "dpcfg_defines.svh"
module dual_port_pin_config_test;
   logic        pclk, presetn, psel, penable, pwrite, stop_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r, sh [9];
   logic [31:0] seed = 32'h7cf3;       // Random state
   logic        pready, pslverr, err, i3, i2, t61, t60, t11, t10, t01, t00;
   dpcfg_pkg::dpcfg_nib_t  p4_pin_in, p4_pin_out, p4_pin_oe, p4_pullup_en;
   dpcfg_pkg::dpcfg_nib_t  p4_analog_in, ext4, ext4_drv, ie, km;
   dpcfg_pkg::dpcfg_byte_t p8_pin_in, p8_pullup_en, p8_input_en;
   int          error_cnt, checks;
   int          cyc = 0;               // Cycle count for timeout
   // Register map: byte address and writable bits
   logic [11:0] adr [9] = '{12'h000, 12'h004, 12'h00c, 12'h010, 12'h02c,
      12'h038, `DPCFG_OFF_P8_FSB, `DPCFG_OFF_P8_PUP, `DPCFG_OFF_P8_IE};
   logic [31:0] msk [9] = '{32'hf, 32'hf, 32'h3, 32'hf, 32'hf, 32'hf,
      32'hc0, 32'hff, 32'hff};
   logic [11:0] bad [4] = '{12'h008, 12'h014, 12'h030, 12'h03c};
   dpcfg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_mode(stop_mode), .p4_pin_in(p4_pin_in), .p4_pin_out(p4_pin_out),
      .p4_pin_oe(p4_pin_oe), .p4_pullup_en(p4_pullup_en),
      .p4_analog_in(p4_analog_in), .ext_irq_in3(i3), .ext_irq_in2(i2),
      .timer6_capture_in1(t61), .timer6_capture_in0(t60),
      .timer1_capture_in1(t11), .timer1_capture_in0(t10),
      .p8_pin_in(p8_pin_in), .p8_pullup_en(p8_pullup_en),
      .p8_input_en(p8_input_en), .timer0_capture_in1(t01),
      .timer0_capture_in0(t00));
   dpcfg_pin_model pin_u (.pclk(pclk), .p4_pin_out(p4_pin_out),
      .p4_pin_oe(p4_pin_oe), .p4_pullup_en(p4_pullup_en), .ext4(ext4),
      .ext4_drv(ext4_drv), .p4_pin_in(p4_pin_in));
   // Clock and hang guard
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt = error_cnt + 1;
         tally_and_finish();
      end
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Driver enable: output control and no select bit set
   function dpcfg_pkg::dpcfg_nib_t exp_oe();
      return sh[1][3:0] & ~(sh[2][3:0] | sh[3][3:0]);
   endfunction : exp_oe
   task check_eq(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check_eq
   // One APB transfer, waits for pready
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task check_regs();
      for (int i = 1; i < 9; i++)
      begin
         apb(1'b0, adr[i], 32'h0);
         check_eq(rd, sh[i]);
         check_eq(err, 1'b0);
      end
      ie = sh[5][3:0];
      km = ~(sh[2][3:0] | sh[3][3:0]) & (exp_oe() | ext4_drv | sh[4][3:0]);
      apb(1'b0, 12'h000, 32'h0);
      check_eq(rd & km, {28'h0, ((exp_oe() & sh[0][3:0])
         | (~exp_oe() & p4_pin_in & ie)) & km});
   endtask : check_regs
   task check_pins();
      ie = sh[5][3:0];
      check_eq(p4_pin_oe, exp_oe());
      check_eq(p4_pin_out, sh[0][3:0]);
      check_eq(p4_pullup_en, sh[4][3:0]);
      check_eq(p4_analog_in, {28'h0, ~ie & ~sh[4][3:0]});
      check_eq({i3, i2}, p4_pin_in[1:0] & ie[1:0] & {2{~stop_mode}});
      check_eq({t61, t60, t11, t10}, p4_pin_in & ie & sh[3][3:0]);
      check_eq({t01, t00}, p8_pin_in[7:6] & sh[8][7:6] & sh[6][7:6]);
      check_eq(p8_pullup_en, sh[7][7:0]);
      check_eq(p8_input_en, sh[8][7:0]);
   endtask : check_pins
   task tally_and_finish();
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   // Reset, refused offsets, then random configurations
   initial
   begin
      {presetn, psel, penable, pwrite, stop_mode} = 5'h0;
      {paddr, pwdata, ext4, ext4_drv, p8_pin_in} = '0;
      error_cnt = 0;
      checks = 0;
      for (int i = 0; i < 9; i++)
         sh[i] = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      #1 check_pins();
      check_regs();
      foreach (bad[j])
      begin
         apb(1'b1, bad[j], 32'hffff_ffff);
         check_eq(err, 1'b1);
         apb(1'b0, bad[j], 32'h0);
         check_eq(err, 1'b1);
         check_eq(rd, 32'h0);
      end
      check_regs();
      repeat (80)
      begin
         for (int i = 0; i < 9; i++)
         begin
            sh[i] = rnd() & msk[i];
            if (i == 3)
               sh[3] = sh[3] & ~sh[2];
            apb(1'b1, adr[i], sh[i] | ~msk[i]);
         end
         r = rnd();
         ext4 <= r[3:0];
         ext4_drv <= r[7:4];
         p8_pin_in <= r[15:8];
         stop_mode <= r[16];
         @(posedge pclk);
         #1 check_pins();
         check_regs();
      end
      tally_and_finish();
   end
endmodule : dual_port_pin_config_test
